// ### hdl/cpa_pkg.sv
`default_nettype none
package cpa_pkg;
  // Clock and time base
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_S = 1;
  localparam int CYC_PER_SEC = CLK_HZ * TICK_S;
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
  // Timing in seconds
  localparam int SIL_MIN = 15;
  localparam int SIL_S = SIL_MIN * 60;
  localparam int FULL_S = 30;
  localparam int RING_ON_S = 2;
  localparam int RING_PER_S = 5;
  localparam int SAVER_MIN = 5;
  localparam int SAVER_S = SAVER_MIN * 60;
  localparam int WARM_MIN = 3;
  localparam int WARM_S = WARM_MIN * 60;
  localparam int HOLD_S = 3;
  localparam int POR_S = 2;
  localparam int REV_S = 3;
  // Auto-off timers
  localparam int STEP_MIN = 15;
  localparam int STEP_S = STEP_MIN * 60;
  localparam int MAX_MIN = 480;
  localparam logic [5:0] MAX_STEPS = 6'(MAX_MIN / STEP_MIN);
  // Register offsets and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TMR = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CTRL_NITE = 0;
  localparam int CTRL_PWEN = 1;
  localparam int CTRL_PAT = 2;
  localparam int TMR_FLD = 8;
  // Reset values
  localparam logic CTRL_NITE_RST = 1'h0;
  localparam logic CTRL_PWEN_RST = 1'h1;
  localparam logic [2:0] PW_PAT_RST = 3'h2;
  localparam logic [5:0] DUR_LIGHT_RST = 6'h1C;
  localparam logic [5:0] DUR_UV_RST = 6'h03;
  localparam logic [5:0] DUR_OUT_RST = 6'h20;
  // Modes and screens
  typedef enum logic [1:0] {CPA_STBY = 2'b00, CPA_WARM = 2'b01, CPA_RUN = 2'b10} cpa_mode_e;
  typedef enum logic [1:0] {CPA_SCR_POR = 2'b00, CPA_SCR_REV = 2'b01,
                            CPA_SCR_MAIN = 2'b10} cpa_scr_e;
  // Operator keys
  typedef struct packed {
    logic back; logic accept; logic down; logic up; logic silence;
    logic outlet; logic uv; logic light; logic hidden; logic blower;
  } cpa_keys_s;
  // Status inputs from sensors, window switches and motor
  typedef struct packed {
    logic fw_new; logic board_fail; logic vel_sens_err; logic vel_comm_fail;
    logic vel_alarm; logic blower_inhib; logic rpm_fail; logic win_closed;
    logic win_high; logic win_low; logic win_ok; logic uv_replace;
  } cpa_sens_s;
  // Indicators
  typedef struct packed {
    logic blower_grn; logic blower_red; logic light; logic uv; logic outlet;
    logic alarm_red;
  } cpa_leds_s;
  // Load switches
  typedef struct packed {
    logic blower; logic motor_reduced; logic outlet; logic uv; logic light;
  } cpa_loads_s;
endpackage
`default_nettype wire

// ### hdl/cpa_panel_ctrl.sv
`default_nettype none
module cpa_panel_ctrl #(
  parameter int CYC_PER_SEC = cpa_pkg::CYC_PER_SEC, // Clocks per second tick
  parameter int DEB_CYC = cpa_pkg::DEB_CYC // Debounce stable time in clocks
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst_n, // Power-on reset, active low
  input wire logic pwr_restored_i, // Pulse when supply comes back
  input wire cpa_pkg::cpa_keys_s keys_i, // Raw key levels, high pressed
  input wire cpa_pkg::cpa_sens_s sens_i, // Sensor and switch status
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall request
  output cpa_pkg::cpa_leds_s leds_o, // Indicator LEDs
  output cpa_pkg::cpa_loads_s loads_o, // Load switches
  output logic buzzer_o, // Audible alarm
  output logic click_o, // Key feedback pulse
  output logic disp_on_o, // Display lit
  output cpa_pkg::cpa_scr_e scr_o, // Screen being shown
  output logic [3:0] msg_o, // Message code, 0 none
  output logic readings_o, // Airflow readings shown
  output logic page_o, // Run page, 1 timers
  output logic [2:0] tmr_show_o, // Timers listed on timer page
  output logic menu_o, // Menu open
  output logic menu_lvl_o, // Menu depth
  output logic [1:0] menu_item_o, // Highlighted item
  output logic edit_o // Edit mode
);
  // Whole module state
  typedef struct packed {
    logic [31:0] presc; logic tick; logic blink;
    logic [31:0] deb; cpa_pkg::cpa_keys_s kraw; cpa_pkg::cpa_keys_s kst;
    cpa_pkg::cpa_mode_e mode; logic [7:0] warm; logic [1:0] pwcnt;
    logic nite_cfg; logic pw_en; logic [2:0] pw_pat;
    logic [2:0][5:0] dur; logic [2:0] load; logic [2:0][14:0] tmr;
    logic pwrup; cpa_pkg::cpa_scr_e scr; logic [2:0] scrcnt;
    logic [8:0] idle; logic [1:0] hold; logic held;
    logic menu; logic lvl; logic [1:0] item; logic edit; logic [5:0] eval; logic page;
    logic alarm; logic [4:0] full; logic [2:0] ring; logic [9:0] sil;
    logic ack; logic [31:0] rdata; logic click;
    cpa_pkg::cpa_leds_s led; cpa_pkg::cpa_loads_s ld; logic [3:0] msg; logic buzz;
  } cpa_state_s;

  cpa_state_s st_q, st_d;
  cpa_pkg::cpa_keys_s ev; // One-cycle key events
  logic alarm_w; // Any alarm present
  logic night_w; // Night hold active
  logic [12:0] cond_w; // Ranked message conditions
  logic req_w; // Bus request
  logic kv_w; // Blower or hidden press
  logic match_w; // Password key matches
  logic silent_w; // Suppress key click

  // Highest ranked condition, bit 0 first
  function automatic logic [3:0] cpa_prio(input logic [12:0] c);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 12; i >= 0; i--) begin
      if (c[i]) begin
        p = 4'(i + 1);
      end
    end
    return p;
  endfunction

  // Clamp a timer duration to the longest allowed
  function automatic logic [5:0] cpa_clamp(input logic [5:0] v);
    return (v > cpa_pkg::MAX_STEPS) ? cpa_pkg::MAX_STEPS : v;
  endfunction

  assign req_w = avs_read | avs_write;
  assign avs_waitrequest = req_w & ~st_q.ack;
  assign avs_readdata = st_q.rdata;

  // Outputs from state flops
  assign leds_o = st_q.led;
  assign loads_o = st_q.ld;
  assign buzzer_o = st_q.buzz;
  assign click_o = st_q.click;
  assign disp_on_o = !(st_q.idle == 9'(cpa_pkg::SAVER_S) && !st_q.ld.blower);
  assign scr_o = st_q.scr;
  assign msg_o = st_q.msg;
  assign readings_o = st_q.mode == cpa_pkg::CPA_RUN;
  assign page_o = st_q.page;
  assign tmr_show_o = st_q.page ? st_q.load & {st_q.tmr[2] != 15'h0,
                      st_q.tmr[1] != 15'h0, st_q.tmr[0] != 15'h0} : 3'h0;
  assign menu_o = st_q.menu;
  assign menu_lvl_o = st_q.lvl;
  assign menu_item_o = st_q.item;
  assign edit_o = st_q.edit;

  // Key press events once the debounced level rises
  always_comb begin
    if (st_q.kraw == keys_i && st_q.deb == 32'(DEB_CYC - 1)) begin
      ev = st_q.kraw & ~st_q.kst;
    end else begin
      ev = '0;
    end
  end

  // Alarm, night hold and message conditions
  always_comb begin
    alarm_w = sens_i.board_fail | sens_i.vel_sens_err | sens_i.vel_comm_fail
            | sens_i.blower_inhib | sens_i.rpm_fail
            | (sens_i.vel_alarm & st_q.mode == cpa_pkg::CPA_RUN)
            | (sens_i.win_high & st_q.mode != cpa_pkg::CPA_STBY)
            | (sens_i.win_low & st_q.mode == cpa_pkg::CPA_RUN);
    night_w = st_q.nite_cfg & st_q.mode != cpa_pkg::CPA_STBY & sens_i.win_closed;
    cond_w = {sens_i.uv_replace, sens_i.win_low, sens_i.win_high, sens_i.win_closed,
              night_w, sens_i.rpm_fail, sens_i.blower_inhib, sens_i.vel_alarm,
              sens_i.vel_comm_fail, sens_i.vel_sens_err, st_q.pwrup,
              sens_i.board_fail, sens_i.fw_new};
    kv_w = ev.blower | ev.hidden;
    match_w = ev.hidden == st_q.pw_pat[2'(2'h2 - st_q.pwcnt)];
    silent_w = st_q.mode == cpa_pkg::CPA_STBY && st_q.pw_en && kv_w && !st_q.menu
             && !(match_w && st_q.pwcnt == 2'h2);
  end

  // Next state
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    // Single seconds tick for every timer but the debounce, which counts clocks
    if (st_q.presc == 32'(CYC_PER_SEC - 1)) begin
      st_d.presc = 32'h0;
      st_d.tick = 1'b1;
      st_d.blink = ~st_q.blink;
    end else begin
      st_d.presc = st_q.presc + 32'h1;
    end
    // Debounce: restart whenever the raw level moves
    if (st_q.kraw != keys_i) begin
      st_d.kraw = keys_i;
      st_d.deb = 32'h0;
    end else if (st_q.deb != 32'(DEB_CYC - 1)) begin
      st_d.deb = st_q.deb + 32'h1;
    end else begin
      st_d.kst = st_q.kraw;
    end
    st_d.click = (ev != '0) && !silent_w;
    // Any key acknowledges the power-up status
    if (ev != '0) begin
      st_d.pwrup = 1'b0;
      st_d.idle = 9'h0;
    end else if (st_q.tick && st_q.idle != 9'(cpa_pkg::SAVER_S)) begin
      st_d.idle = st_q.idle + 9'h1;
    end
    // Power-up screens
    if (st_q.tick && st_q.scr != cpa_pkg::CPA_SCR_MAIN) begin
      st_d.scrcnt = st_q.scrcnt + 3'h1;
      if (st_q.scr == cpa_pkg::CPA_SCR_POR && st_q.scrcnt == 3'(cpa_pkg::POR_S - 1)) begin
        st_d.scr = cpa_pkg::CPA_SCR_REV;
        st_d.scrcnt = 3'h0;
      end else if (st_q.scr == cpa_pkg::CPA_SCR_REV
                   && st_q.scrcnt == 3'(cpa_pkg::REV_S - 1)) begin
        st_d.scr = cpa_pkg::CPA_SCR_MAIN;
      end
    end
    // Blower, password and modes
    case (st_q.mode)
      cpa_pkg::CPA_STBY: begin
        if (kv_w && !st_q.menu) begin
          if (st_q.pw_en) begin
            if (match_w && st_q.pwcnt == 2'h2) begin
              st_d.pwcnt = 2'h0;
              if (sens_i.win_ok) begin
                st_d.mode = cpa_pkg::CPA_WARM;
                st_d.warm = 8'(cpa_pkg::WARM_S);
              end
            end else if (match_w) begin
              st_d.pwcnt = st_q.pwcnt + 2'h1;
            end else begin
              st_d.pwcnt = (ev.hidden == st_q.pw_pat[2]) ? 2'h1 : 2'h0;
            end
          end else if (ev.blower && sens_i.win_ok) begin
            st_d.mode = cpa_pkg::CPA_WARM;
            st_d.warm = 8'(cpa_pkg::WARM_S);
          end
        end
      end
      cpa_pkg::CPA_WARM: begin
        if (ev.blower && !st_q.menu) begin
          st_d.mode = cpa_pkg::CPA_STBY;
        end else if (st_q.tick) begin
          st_d.warm = st_q.warm - 8'h1;
          if (st_q.warm == 8'h1) begin
            st_d.mode = cpa_pkg::CPA_RUN;
          end
        end
      end
      cpa_pkg::CPA_RUN: begin
        if (ev.blower && !st_q.menu) begin
          st_d.mode = cpa_pkg::CPA_STBY;
        end else if ((ev.up || ev.down) && !st_q.menu) begin
          st_d.page = ~st_q.page;
        end
      end
      default: begin
        st_d.mode = cpa_pkg::CPA_STBY;
      end
    endcase
    if (st_d.mode == cpa_pkg::CPA_STBY) begin
      st_d.page = 1'b0;
    end
    // Load toggles and auto-off countdowns
    for (int i = 0; i < 3; i++) begin
      if (!st_q.menu && ev[2 + i]) begin
        st_d.load[i] = ~st_q.load[i];
        st_d.tmr[i] = st_q.load[i] ? 15'h0 : 15'(st_q.dur[i] * cpa_pkg::STEP_S);
      end else if (st_q.tick && st_q.tmr[i] != 15'h0) begin
        st_d.tmr[i] = st_q.tmr[i] - 15'h1;
        if (st_q.tmr[i] == 15'h1) begin
          st_d.load[i] = 1'b0;
        end
      end
    end
    if (night_w) begin
      st_d.load[0] = 1'b0;
      st_d.tmr[0] = 15'h0;
    end
    // Accept held opens the menu
    if (!st_q.kst.accept) begin
      st_d.hold = 2'h0;
      st_d.held = 1'b0;
    end else if (st_q.tick && !st_q.held) begin
      st_d.hold = st_q.hold + 2'h1;
      if (st_q.hold == 2'(cpa_pkg::HOLD_S - 1)) begin
        st_d.menu = 1'b1;
        st_d.held = 1'b1;
        st_d.lvl = 1'b0;
        st_d.item = 2'h0;
        st_d.edit = 1'b0;
      end
    end
    // Menu navigation
    if (st_q.menu) begin
      if (ev.silence) begin
        st_d.menu = 1'b0;
        st_d.edit = 1'b0;
        st_d.lvl = 1'b0;
      end else if (st_q.edit) begin
        if (ev.up) begin
          st_d.eval = (st_q.item == 2'h3) ? ~st_q.eval : cpa_clamp(st_q.eval + 6'h1);
        end else if (ev.down) begin
          st_d.eval = (st_q.item == 2'h3) ? ~st_q.eval
                    : (st_q.eval == 6'h0) ? 6'h0 : st_q.eval - 6'h1;
        end else if (ev.accept) begin
          st_d.edit = 1'b0;
          if (st_q.item == 2'h3) begin
            st_d.nite_cfg = st_q.eval[0];
          end else begin
            st_d.dur[st_q.item] = cpa_clamp(st_q.eval);
          end
        end else if (ev.back) begin
          st_d.edit = 1'b0;
        end
      end else if (ev.up) begin
        st_d.item = st_q.item + 2'h1;
      end else if (ev.down) begin
        st_d.item = st_q.item - 2'h1;
      end else if (ev.accept) begin
        if (!st_q.lvl) begin
          st_d.lvl = 1'b1;
        end else begin
          st_d.edit = 1'b1;
          st_d.eval = (st_q.item == 2'h3) ? {5'h0, st_q.nite_cfg} : st_q.dur[st_q.item];
        end
      end else if (ev.back) begin
        st_d.lvl = 1'b0;
        st_d.menu = st_q.lvl;
      end
    end
    // Audible alarm sequencing
    st_d.alarm = alarm_w;
    if (alarm_w && !st_q.alarm) begin
      st_d.full = 5'(cpa_pkg::FULL_S);
      st_d.ring = 3'h0;
      st_d.sil = 10'h0;
    end else if (st_q.tick) begin
      if (st_q.full != 5'h0) begin
        st_d.full = st_q.full - 5'h1;
      end else begin
        st_d.ring = (st_q.ring == 3'(cpa_pkg::RING_PER_S - 1)) ? 3'h0 : st_q.ring + 3'h1;
      end
      if (st_q.sil != 10'h0) begin
        st_d.sil = st_q.sil - 10'h1;
      end
    end
    if (ev.silence && alarm_w) begin
      st_d.sil = 10'(cpa_pkg::SIL_S);
      st_d.full = 5'h0;
      st_d.ring = 3'h0;
    end
    st_d.buzz = alarm_w && st_q.sil == 10'h0
              && (st_q.full != 5'h0 || st_q.ring < 3'(cpa_pkg::RING_ON_S));
    // Indicators, loads and message line
    st_d.msg = cpa_prio(cond_w);
    st_d.led.alarm_red = alarm_w | (st_q.pwrup & st_q.blink);
    st_d.led.blower_red = (sens_i.rpm_fail | sens_i.blower_inhib
                         | (sens_i.vel_alarm & st_q.mode == cpa_pkg::CPA_RUN))
                         & st_q.blink;
    st_d.led.blower_grn = !st_d.led.blower_red && (st_q.mode == cpa_pkg::CPA_RUN
                        && !night_w || st_q.blink && st_q.mode != cpa_pkg::CPA_STBY);
    {st_d.led.outlet, st_d.led.uv, st_d.led.light} = st_q.load
        & ~({st_q.tmr[2] != 15'h0, st_q.tmr[1] != 15'h0, st_q.tmr[0] != 15'h0}
            & {3{~st_q.blink}});
    st_d.ld.blower = st_q.mode != cpa_pkg::CPA_STBY;
    st_d.ld.motor_reduced = night_w;
    {st_d.ld.outlet, st_d.ld.uv, st_d.ld.light} = st_q.load;
    // Bus slave, one wait state
    st_d.ack = req_w & ~st_q.ack;
    if (req_w && !st_q.ack) begin
      case (avs_address)
        cpa_pkg::REG_CTRL: st_d.rdata = {27'h0, st_q.pw_pat, st_q.pw_en, st_q.nite_cfg};
        cpa_pkg::REG_TMR: st_d.rdata = {10'h0, st_q.dur[2], 2'h0, st_q.dur[1],
                                        2'h0, st_q.dur[0]};
        cpa_pkg::REG_STAT: st_d.rdata = {19'h0, st_q.menu, !disp_on_o, st_q.pwrup,
                                         st_q.buzz, st_q.alarm, st_q.msg, 2'h0, st_q.mode};
        default: st_d.rdata = 32'h0;
      endcase
    end
    if (avs_write && st_q.ack) begin
      if (avs_address == cpa_pkg::REG_CTRL) begin
        st_d.nite_cfg = avs_writedata[cpa_pkg::CTRL_NITE];
        st_d.pw_en = avs_writedata[cpa_pkg::CTRL_PWEN];
        st_d.pw_pat = avs_writedata[cpa_pkg::CTRL_PAT +: 3];
      end else if (avs_address == cpa_pkg::REG_TMR) begin
        for (int i = 0; i < 3; i++) begin
          st_d.dur[i] = cpa_clamp(avs_writedata[i * cpa_pkg::TMR_FLD +: 6]);
        end
      end
    end
    // Supply return: flag it, replay the start screens, keep all else
    if (pwr_restored_i) begin
      st_d.pwrup = 1'b1;
      st_d.scr = cpa_pkg::CPA_SCR_POR;
      st_d.scrcnt = 3'h0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.pwrup <= 1'b1;
      st_q.nite_cfg <= cpa_pkg::CTRL_NITE_RST;
      st_q.pw_en <= cpa_pkg::CTRL_PWEN_RST;
      st_q.pw_pat <= cpa_pkg::PW_PAT_RST;
      st_q.dur <= {cpa_pkg::DUR_OUT_RST, cpa_pkg::DUR_UV_RST, cpa_pkg::DUR_LIGHT_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_red_on_alarm: assert property (alarm_w |=> leds_o.alarm_red)
    else $error("red LED dark during alarm");
  a_pwrup_acked: assert property ((ev != '0) && !pwr_restored_i |=> !st_q.pwrup)
    else $error("power-up flag not cleared by key");
  a_silence_mutes: assert property (st_q.sil != 10'h0 |=> !buzzer_o)
    else $error("buzzer sounds while silenced");
  a_silence_exit: assert property (ev.silence |=> !st_q.menu)
    else $error("menu stayed open after silence");
  a_full_tone: assert property (alarm_w && st_q.alarm && st_q.full != 5'h0
    && st_q.sil == 10'h0 |=> buzzer_o)
    else $error("buzzer off in full tone phase");
  a_run_window: assert property (st_q.mode == cpa_pkg::CPA_STBY
    && st_d.mode == cpa_pkg::CPA_WARM |-> sens_i.win_ok)
    else $error("run started with window out of height");
  a_warm_end: assert property (st_q.mode == cpa_pkg::CPA_WARM && st_q.tick
    && st_q.warm == 8'h1 && !ev.blower |=> readings_o)
    else $error("warm-up did not finish");
  a_night_light: assert property (night_w ##1 night_w |=> !loads_o.light)
    else $error("light on during night hold");
  a_msg_first: assert property (sens_i.fw_new |=> msg_o == 4'h1)
    else $error("wrong message priority");
  a_dur_limit: assert property (st_q.dur[2] <= cpa_pkg::MAX_STEPS)
    else $error("timer duration above limit");
endmodule
`default_nettype wire

// ### verif/cpa_operator_model.sv
`default_nettype none
module cpa_operator_model #(
  parameter int DEB = 4 // Debounce time of the panel in clocks
) (
  input wire logic clk, // System clock
  output var cpa_pkg::cpa_keys_s keys_o, // Key levels, high pressed
  output var cpa_pkg::cpa_sens_s sens_o // Switch and sensor levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle panel: no key down, no status raised
  initial begin
    keys_o = '0;
    sens_o = '0;
  end
  // Press one key for hold clocks, then stay released long enough to settle
  task automatic press(input int k, input int hold);
    @(posedge clk);
    keys_o[k] <= 1'b1;
    repeat (hold) @(posedge clk);
    keys_o[k] <= 1'b0;
    repeat (DEB + 3) @(posedge clk);
  endtask
  // Change switch and sensor levels at a clock edge
  task automatic set_sens(input logic [11:0] v);
    @(posedge clk);
    sens_o <= v;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEC = 20; // Clocks per second tick, shortened
  localparam int DEB = 4; // Debounce clocks, shortened
  localparam int H = DEB + 2; // Plain key hold
  localparam int CEIL = 60000; // Cycle ceiling for the whole run
  logic clk, rst_n, pwr_restored, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, msg;
  logic [31:0] avs_writedata, avs_readdata, d;
  cpa_pkg::cpa_keys_s keys;
  cpa_pkg::cpa_sens_s sens;
  cpa_pkg::cpa_leds_s leds;
  cpa_pkg::cpa_loads_s loads;
  cpa_pkg::cpa_scr_e scr;
  logic buzzer, disp_on, readings, menu, menu_lvl, edit, a, click, page;
  logic [1:0] item;
  logic [2:0] tmr_show;
  int n_mismatch = 0, total_checks = 0, cyc = 0, clicks = 0, base = 0;
  cpa_operator_model #(.DEB(DEB)) op (.clk(clk), .keys_o(keys), .sens_o(sens));
  cpa_panel_ctrl #(.CYC_PER_SEC(SEC), .DEB_CYC(DEB)) uut (
    .clk(clk), .rst_n(rst_n), .pwr_restored_i(pwr_restored), .keys_i(keys),
    .sens_i(sens), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .leds_o(leds), .loads_o(loads), .buzzer_o(buzzer), .click_o(click),
    .disp_on_o(disp_on), .scr_o(scr), .msg_o(msg), .readings_o(readings),
    .page_o(page), .tmr_show_o(tmr_show), .menu_o(menu), .menu_lvl_o(menu_lvl),
    .menu_item_o(item), .edit_o(edit));
  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare one bit
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask
  // Compare one word
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait n edges, then settle at the falling edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // One bus access held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // LED k must change over one second
  task automatic blink(input int k);
    @(negedge clk);
    a = leds[k];
    wt(SEC);
    chk_bit(a ^ leds[k], 1'b1);
  endtask
  // LED k must stay lit over one second
  task automatic steady(input int k);
    @(negedge clk);
    a = leds[k];
    wt(SEC);
    chk_bit(a & leds[k], 1'b1);
  endtask
  // Print the counts and the verdict, then stop
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Hang guard and key click counter
  always @(posedge clk) begin
    cyc++;
    if (click === 1'b1) begin
      clicks++;
    end
    if (cyc == CEIL) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    pwr_restored = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, cpa_pkg::REG_CTRL, 32'h0);
    chk_word(d, 32'h0000000A);
    bus(0, cpa_pkg::REG_TMR, 32'h0);
    chk_word(d, 32'h0020031C);
    bus(1, 4'hC, 32'hFFFFFFFF);
    bus(0, 4'hC, 32'h0);
    chk_word(d, 32'h00000000);
    bus(1, cpa_pkg::REG_TMR, 32'h0000033F);
    bus(0, cpa_pkg::REG_TMR, 32'h0);
    chk_word(d, 32'h00000320);
    $display("done: registers");
    blink(0);
    bus(1, cpa_pkg::REG_TMR, 32'h00200300);
    op.press(2, H);
    wt(1);
    chk_bit(loads.light, 1'b1);
    steady(3);
    bus(0, cpa_pkg::REG_STAT, 32'h0);
    chk_bit(d[10], 1'b0);
    op.press(2, H);
    wt(1);
    chk_bit(loads.light, 1'b0);
    bus(1, cpa_pkg::REG_TMR, 32'h00200301);
    op.press(2, H);
    blink(3);
    op.press(2, H);
    $display("done: loads");
    wt(302 * SEC);
    chk_bit(disp_on, 1'b0);
    op.press(5, H);
    wt(1);
    chk_bit(disp_on, 1'b1);
    $display("done: saver");
    bus(1, cpa_pkg::REG_CTRL, 32'h00000008);
    op.press(0, H);
    bus(0, cpa_pkg::REG_STAT, 32'h0);
    chk_word({30'h0, d[1:0]}, 32'h0);
    op.set_sens(12'h002);
    op.press(0, H);
    bus(0, cpa_pkg::REG_STAT, 32'h0);
    chk_word({30'h0, d[1:0]}, 32'h1);
    chk_bit(readings, 1'b0);
    chk_bit(loads.blower, 1'b1);
    wt(182 * SEC);
    chk_bit(readings, 1'b1);
    steady(5);
    $display("done: run");
    op.set_sens(12'h022);
    wt(5);
    chk_bit(leds.alarm_red, 1'b1);
    chk_word({28'h0, msg}, 32'h8);
    op.set_sens(12'h422);
    wt(3);
    chk_word({28'h0, msg}, 32'h2);
    op.set_sens(12'h022);
    wt(15 * SEC);
    chk_bit(buzzer, 1'b1);
    wt(18 * SEC + 10);
    chk_bit(buzzer, 1'b0);
    wt(2 * SEC + 10);
    chk_bit(buzzer, 1'b1);
    op.press(5, H);
    wt(2);
    chk_bit(buzzer, 1'b0);
    wt(888 * SEC);
    chk_bit(buzzer, 1'b0);
    wt(12 * SEC);
    chk_bit(buzzer, 1'b1);
    op.set_sens(12'h002);
    wt(3);
    chk_bit(leds.alarm_red | buzzer, 1'b0);
    $display("done: alarm");
    bus(1, cpa_pkg::REG_CTRL, 32'h00000009);
    op.press(2, H);
    op.set_sens(12'h010);
    wt(3);
    chk_bit(loads.motor_reduced & !loads.light, 1'b1);
    chk_word({28'h0, msg}, 32'h9);
    blink(5);
    op.set_sens(12'h002);
    bus(1, cpa_pkg::REG_CTRL, 32'h00000008);
    $display("done: night hold");
    @(posedge clk);
    pwr_restored <= 1'b1;
    @(posedge clk);
    pwr_restored <= 1'b0;
    wt(2);
    chk_bit(scr === cpa_pkg::CPA_SCR_POR, 1'b1);
    chk_bit(loads.blower, 1'b1);
    wt(6 * SEC);
    chk_bit(scr === cpa_pkg::CPA_SCR_MAIN, 1'b1);
    op.press(9, H);
    bus(0, cpa_pkg::REG_STAT, 32'h0);
    chk_bit(d[10], 1'b0);
    $display("done: power restore");
    op.press(8, 70);
    wt(1);
    chk_bit(menu & (item === 2'h0), 1'b1);
    for (int k = 6; k <= 7; k++) begin
      for (int i = 0; i < 4; i++) begin
        op.press(k, H);
        if (i == 0) begin
          chk_word({30'h0, item}, (k == 6) ? 32'h1 : 32'h3);
        end
      end
      chk_word({30'h0, item}, 32'h0);
    end
    op.press(8, H);
    chk_bit(menu_lvl, 1'b1);
    op.press(8, H);
    chk_bit(edit, 1'b1);
    op.press(9, H);
    chk_bit(edit, 1'b0);
    op.press(9, H);
    chk_bit(menu & !menu_lvl, 1'b1);
    op.press(5, H);
    chk_bit(menu, 1'b0);
    $display("done: menu");
    op.press(3, H);
    op.press(6, H);
    chk_bit(page, 1'b1);
    chk_word({29'h0, tmr_show}, 32'h2);
    op.press(7, H);
    chk_word({28'h0, page, tmr_show}, 32'h0);
    $display("done: pages");
    op.press(0, H);
    bus(1, cpa_pkg::REG_CTRL, 32'h0000000A);
    base = clicks;
    op.press(0, H);
    op.press(1, H);
    chk_word(32'(clicks - base), 32'h0);
    bus(0, cpa_pkg::REG_STAT, 32'h0);
    chk_word({30'h0, d[1:0]}, 32'h0);
    op.press(0, H);
    chk_word(32'(clicks - base), 32'h1);
    bus(0, cpa_pkg::REG_STAT, 32'h0);
    chk_word({30'h0, d[1:0]}, 32'h1);
    $display("done: password");
    op.set_sens(12'h00A);
    wt(3);
    chk_bit(leds.alarm_red & buzzer, 1'b1);
    op.press(5, H);
    wt(2);
    chk_bit(buzzer, 1'b0);
    op.set_sens(12'h002);
    $display("done: warm-up window");
    tally_and_finish();
  end
endmodule
`default_nettype wire
